/* File: rtl/chr_device.sv */
`timescale 1ns/1ps
// What this block does
// - Fault clear register: 1 requests, 0 withdraws
// - Motor faults stay latched until cleared or reset
// - Bit 0 clears left/right motor faults
// - Request held 500 ms before acceptance
// - Bits 8/9 set aux pin direction
// - Bits 12/13 drive aux when output
// - Other aux bits reserved; host ignores
// - Host aux control only with usage none
// - Stop word: 0 none, 1 stop, 2 clear
// - Upstream jam clear on rising edge
// - Downstream jam clear on rising edge
// - Held one gives no further retries
// - Flow registers act from local zone
// - Codes 0-4 normal, accumulate, release modes
// - Codes 5-7 forward, reverse, maintenance
// - Codes 10/11 default or opposite direction
// - High byte zone count, zero all
// - Accumulate only after clear-to-blocked change
module chr_device #(
  parameter int HOLD_CYCLES = chr_pkg::HOLD_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Host writes
  chr_if.device bus,
  // Motor faults
  input wire logic fault_left_i,
  input wire logic fault_right_i,
  output logic fault_left_o,
  output logic fault_right_o,
  // Aux pins
  input wire logic aux_usage_none_l_i,
  input wire logic aux_usage_none_r_i,
  input wire logic aux_in_l_i,
  input wire logic aux_in_r_i,
  output logic aux_out_l_o,
  output logic aux_out_r_o,
  output logic aux_oe_l_o,
  output logic aux_oe_r_o,
  output logic [1:0] aux_in_o,
  // Stop group
  output logic stopped_o,
  // Jam
  input wire logic up_jam_i,
  input wire logic dn_jam_i,
  output logic up_jam_clear_o,
  output logic dn_jam_clear_o,
  // Zone flow
  input wire logic up_blocked_i,
  input wire logic dn_blocked_i,
  output chr_pkg::chr_mode_type up_mode_o,
  output chr_pkg::chr_mode_type dn_mode_o,
  output logic up_reverse_o,
  output logic dn_reverse_o,
  output logic up_alt_release_o,
  output logic dn_alt_release_o,
  output logic [7:0] up_zones_o,
  output logic [7:0] dn_zones_o,
  output logic up_accumulate_o,
  output logic dn_accumulate_o
);
  logic [15:0] fclr_r;
  logic [15:0] aux_r;
  logic up_jam_r;
  logic dn_jam_r;
  logic [31:0] hold_r;
  logic fault_l_r;
  logic fault_r_r;
  logic stopped_r;
  logic up_pulse_r;
  logic dn_pulse_r;
  logic [1:0] aux_in_r;
  logic wr_stop, wr_fclr, wr_aux, wr_upj, wr_dnj, wr_upf, wr_dnf;
  logic hold_done;
  logic up_rise, dn_rise;
  assign wr_stop = bus.wr_en && (bus.wr_addr == chr_pkg::ADDR_STOP_CMD);
  assign wr_fclr = bus.wr_en && (bus.wr_addr == chr_pkg::ADDR_FAULT_CLR);
  assign wr_aux = bus.wr_en && (bus.wr_addr == chr_pkg::ADDR_AUX_CTRL);
  assign wr_upj = bus.wr_en && (bus.wr_addr == chr_pkg::ADDR_UP_JAM);
  assign wr_dnj = bus.wr_en && (bus.wr_addr == chr_pkg::ADDR_DN_JAM);
  assign wr_upf = bus.wr_en && (bus.wr_addr == chr_pkg::ADDR_UP_FLOW);
  assign wr_dnf = bus.wr_en && (bus.wr_addr == chr_pkg::ADDR_DN_FLOW);
  assign hold_done = (hold_r >= 32'(HOLD_CYCLES));
  assign up_rise = wr_upj && bus.wr_data[chr_pkg::JAM_BIT] && !up_jam_r;
  assign dn_rise = wr_dnj && bus.wr_data[chr_pkg::JAM_BIT] && !dn_jam_r;
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      fclr_r <= 16'h0000;
      aux_r <= 16'h0000;
      up_jam_r <= 1'b0;
      dn_jam_r <= 1'b0;
    end
    else
    begin
      if (wr_fclr)
        fclr_r <= bus.wr_data;
      // host writes only when usage none
      // Usage is sampled at the write; a later unlock keeps the old bits
      if (wr_aux)
      begin
        if (aux_usage_none_l_i)
        begin
          aux_r[chr_pkg::AUX_DIR_L_BIT] <= bus.wr_data[chr_pkg::AUX_DIR_L_BIT];
          aux_r[chr_pkg::AUX_OUT_L_BIT] <= bus.wr_data[chr_pkg::AUX_OUT_L_BIT];
        end
        if (aux_usage_none_r_i)
        begin
          aux_r[chr_pkg::AUX_DIR_R_BIT] <= bus.wr_data[chr_pkg::AUX_DIR_R_BIT];
          aux_r[chr_pkg::AUX_OUT_R_BIT] <= bus.wr_data[chr_pkg::AUX_OUT_R_BIT];
        end
      end
      if (wr_upj)
        up_jam_r <= bus.wr_data[chr_pkg::JAM_BIT];
      if (wr_dnj)
        dn_jam_r <= bus.wr_data[chr_pkg::JAM_BIT];
    end
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      hold_r <= 32'h0000_0000;
      fault_l_r <= 1'b0;
      fault_r_r <= 1'b0;
    end
    else
    begin
      // count continuous hold; a zero restarts it
      if (!fclr_r[chr_pkg::FAULT_CLR_BIT])
        hold_r <= 32'h0000_0000;
      // Saturates at the limit, so a long hold never wraps around
      else if (!hold_done)
        hold_r <= hold_r + 32'h0000_0001;
      // latch faults; set wins over clear
      fault_l_r <= fault_left_i || (fault_l_r && !hold_done);
      fault_r_r <= fault_right_i || (fault_r_r && !hold_done);
    end
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      stopped_r <= 1'b0;
      up_pulse_r <= 1'b0;
      dn_pulse_r <= 1'b0;
      aux_in_r <= 2'h0;
    end
    else
    begin
      if (wr_stop && bus.wr_data == chr_pkg::STOP_SET)
        stopped_r <= 1'b1;
      else if (wr_stop && bus.wr_data == chr_pkg::STOP_CLEAR)
        stopped_r <= 1'b0;
      up_pulse_r <= up_rise && up_jam_i;
      dn_pulse_r <= dn_rise && dn_jam_i;
      aux_in_r <= {aux_in_r_i, aux_in_l_i};
    end
  end
  assign aux_oe_l_o = aux_r[chr_pkg::AUX_DIR_L_BIT];
  assign aux_oe_r_o = aux_r[chr_pkg::AUX_DIR_R_BIT];
  assign aux_out_l_o = aux_r[chr_pkg::AUX_DIR_L_BIT] && aux_r[chr_pkg::AUX_OUT_L_BIT];
  assign aux_out_r_o = aux_r[chr_pkg::AUX_DIR_R_BIT] && aux_r[chr_pkg::AUX_OUT_R_BIT];
  assign aux_in_o = aux_in_r;
  assign fault_left_o = fault_l_r;
  assign fault_right_o = fault_r_r;
  assign stopped_o = stopped_r;
  assign up_jam_clear_o = up_pulse_r;
  assign dn_jam_clear_o = dn_pulse_r;
  chr_flow_unit u_up (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr_upf),
    .data_i(bus.wr_data),
    .zone_blocked_i(up_blocked_i),
    .reg_o(),
    .mode_o(up_mode_o),
    .reverse_o(up_reverse_o),
    .alt_release_o(up_alt_release_o),
    .zone_count_o(up_zones_o),
    .accumulate_o(up_accumulate_o)
  );
  chr_flow_unit u_dn (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .wr_i(wr_dnf),
    .data_i(bus.wr_data),
    .zone_blocked_i(dn_blocked_i),
    .reg_o(),
    .mode_o(dn_mode_o),
    .reverse_o(dn_reverse_o),
    .alt_release_o(dn_alt_release_o),
    .zone_count_o(dn_zones_o),
    .accumulate_o(dn_accumulate_o)
  );
endmodule : chr_device

/* File: rtl/chr_flow_unit.sv */
`timescale 1ns/1ps
module chr_flow_unit (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Command write
  input wire logic wr_i,
  input wire logic [15:0] data_i,
  // Zone status
  input wire logic zone_blocked_i,
  // Applied state
  output logic [15:0] reg_o,
  output chr_pkg::chr_mode_type mode_o,
  output logic reverse_o,
  output logic alt_release_o,
  output logic [7:0] zone_count_o,
  output logic accumulate_o
);
  logic [7:0] code;
  logic known;
  logic armed_r;
  logic blocked_q_r;
  logic [15:0] reg_r;
  chr_pkg::chr_mode_type mode_r;
  logic rev_r;
  logic alt_r;
  logic [7:0] cnt_r;
  logic acc_r;
  logic rise;
  assign code = data_i[7:0];
  assign known = (code <= chr_pkg::FLOW_MAINT) || (code == chr_pkg::FLOW_DIR_DEF)
    || (code == chr_pkg::FLOW_DIR_OPP);
  assign rise = zone_blocked_i && !blocked_q_r;
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      reg_r <= 16'h0000;
      mode_r <= chr_pkg::MODE_NORMAL;
      rev_r <= 1'b0;
      alt_r <= 1'b0;
      cnt_r <= chr_pkg::ZONES_ALL;
      armed_r <= 1'b0;
      acc_r <= 1'b0;
      blocked_q_r <= 1'b0;
    end
    else
    begin
      blocked_q_r <= zone_blocked_i;
      if (wr_i)
        reg_r <= data_i;
      if (armed_r && rise)
      begin
        acc_r <= 1'b1;
        armed_r <= 1'b0;
      end
      else if (acc_r && !zone_blocked_i)
      begin
        acc_r <= 1'b0;
        armed_r <= (mode_r == chr_pkg::MODE_ACCUM);
      end
      // A normal or accumulate command in the same cycle overrides the arming above
      if (wr_i && known)
      begin
        cnt_r <= (data_i[15:8] > chr_pkg::ZONES_MAX) ? chr_pkg::ZONES_MAX : data_i[15:8];
        case (code)
          chr_pkg::FLOW_NORMAL:
          begin
            mode_r <= chr_pkg::MODE_NORMAL;
            acc_r <= 1'b0;
            armed_r <= 1'b0;
          end
          chr_pkg::FLOW_ACCUM_A, chr_pkg::FLOW_ACCUM_B:
          begin
            mode_r <= chr_pkg::MODE_ACCUM;
            // A zone filling in this very cycle still counts as clear to blocked
            armed_r <= !rise;
            acc_r <= rise;
          end
          chr_pkg::FLOW_CHG_REL: alt_r <= 1'b1;
          chr_pkg::FLOW_DEF_REL: alt_r <= 1'b0;
          chr_pkg::FLOW_RUN_FWD: mode_r <= chr_pkg::MODE_RUN_FWD;
          chr_pkg::FLOW_RUN_REV: mode_r <= chr_pkg::MODE_RUN_REV;
          chr_pkg::FLOW_MAINT: mode_r <= chr_pkg::MODE_MAINT;
          chr_pkg::FLOW_DIR_DEF: rev_r <= 1'b0;
          chr_pkg::FLOW_DIR_OPP: rev_r <= 1'b1;
          default: mode_r <= mode_r;
        endcase
      end
    end
  end
  assign reg_o = reg_r;
  assign mode_o = mode_r;
  assign reverse_o = rev_r;
  assign alt_release_o = alt_r;
  assign zone_count_o = cnt_r;
  assign accumulate_o = acc_r;
endmodule : chr_flow_unit

/* File: rtl/chr_host.sv */
`timescale 1ns/1ps
module chr_host (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // User command
  input wire logic cmd_valid_i,
  input wire logic [8:0] cmd_addr_i,
  input wire logic [15:0] cmd_data_i,
  output logic cmd_ready_o,
  // Device writes
  chr_if.host bus
);
  logic wr_r;
  logic [8:0] addr_r;
  logic [15:0] data_r;
  logic [15:0] masked;
  logic [15:0] aux_mask;
  // reserved aux bits written as zero
  assign aux_mask = (16'h0001 << chr_pkg::AUX_DIR_L_BIT) | (16'h0001 << chr_pkg::AUX_DIR_R_BIT)
    | (16'h0001 << chr_pkg::AUX_OUT_L_BIT) | (16'h0001 << chr_pkg::AUX_OUT_R_BIT);
  assign masked = (cmd_addr_i == chr_pkg::ADDR_AUX_CTRL) ? (cmd_data_i & aux_mask) : cmd_data_i;
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      wr_r <= 1'b0;
      addr_r <= 9'h000;
      data_r <= 16'h0000;
    end
    else
    begin
      wr_r <= cmd_valid_i;
      if (cmd_valid_i)
      begin
        addr_r <= cmd_addr_i;
        data_r <= masked;
      end
    end
  end
  assign cmd_ready_o = 1'b1;
  assign bus.wr_en = wr_r;
  assign bus.wr_addr = addr_r;
  assign bus.wr_data = data_r;
endmodule : chr_host

/* File: rtl/chr_if.sv */
`timescale 1ns/1ps
interface chr_if;
  logic wr_en;
  logic [8:0] wr_addr;
  logic [15:0] wr_data;
  modport device (input wr_en, input wr_addr, input wr_data);
  modport host (output wr_en, output wr_addr, output wr_data);
endinterface : chr_if

/* File: rtl/chr_pkg.sv */
package chr_pkg;
  // Register offsets (module address numbers)
  localparam logic [8:0] ADDR_STOP_CMD = 9'h014;
  localparam logic [8:0] ADDR_FAULT_CLR = 9'h016;
  localparam logic [8:0] ADDR_AUX_CTRL = 9'h03f;
  localparam logic [8:0] ADDR_UP_JAM = 9'h06d;
  localparam logic [8:0] ADDR_DN_JAM = 9'h0bd;
  localparam logic [8:0] ADDR_UP_FLOW = 9'h16d;
  localparam logic [8:0] ADDR_DN_FLOW = 9'h177;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  // Field positions
  localparam int FAULT_CLR_BIT = 0;
  localparam int AUX_DIR_L_BIT = 8;
  localparam int AUX_DIR_R_BIT = 9;
  localparam int AUX_OUT_L_BIT = 12;
  localparam int AUX_OUT_R_BIT = 13;
  localparam int JAM_BIT = 0;
  localparam int STATUS_JAM_BIT = 5;
  // Stop command values
  localparam logic [15:0] STOP_NONE = 16'h0000;
  localparam logic [15:0] STOP_SET = 16'h0001;
  localparam logic [15:0] STOP_CLEAR = 16'h0002;
  // Flow mode low byte codes
  localparam logic [7:0] FLOW_NORMAL = 8'h00;
  localparam logic [7:0] FLOW_ACCUM_A = 8'h01;
  localparam logic [7:0] FLOW_ACCUM_B = 8'h02;
  localparam logic [7:0] FLOW_CHG_REL = 8'h03;
  localparam logic [7:0] FLOW_DEF_REL = 8'h04;
  localparam logic [7:0] FLOW_RUN_FWD = 8'h05;
  localparam logic [7:0] FLOW_RUN_REV = 8'h06;
  localparam logic [7:0] FLOW_MAINT = 8'h07;
  localparam logic [7:0] FLOW_DIR_DEF = 8'h0a;
  localparam logic [7:0] FLOW_DIR_OPP = 8'h0b;
  localparam logic [7:0] ZONES_MAX = 8'hdc;
  localparam logic [7:0] ZONES_ALL = 8'h00;
  // Fault clear hold time
  localparam int CLK_HZ = 25000000;
  localparam int HOLD_MS = 500;
  localparam int HOLD_CYC = (CLK_HZ / 1000) * HOLD_MS;
  // Run mode encoding of applied flow state
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_ACCUM = 3'h1,
    MODE_MAINT = 3'h2,
    MODE_RUN_FWD = 3'h3,
    MODE_RUN_REV = 3'h4
  } chr_mode_type;
endpackage : chr_pkg

/* File: sim/chr_asserts.sv */
`timescale 1ns/1ps
module chr_asserts (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Interface
  input wire logic wr_en,
  input wire logic [8:0] wr_addr,
  input wire logic [15:0] wr_data,
  // Device pins
  input wire logic stopped_o,
  input wire logic fault_left_i,
  input wire logic fault_left_o,
  input wire logic aux_usage_none_l_i,
  input wire logic aux_oe_l_o,
  input wire logic up_jam_i,
  input wire logic up_jam_clear_o
);
  logic up_last_r;
  wire stop_wr = wr_en && wr_addr == chr_pkg::ADDR_STOP_CMD;
  wire stop_set = stop_wr && wr_data == chr_pkg::STOP_SET;
  wire stop_clr = stop_wr && wr_data == chr_pkg::STOP_CLEAR;
  wire aux_wr = wr_en && wr_addr == chr_pkg::ADDR_AUX_CTRL;
  wire up_wr = wr_en && wr_addr == chr_pkg::ADDR_UP_JAM;
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // Last written jam bit, so a held 1 is told apart from a fresh edge
  always_ff @(posedge clk_sys_i)
    if (!rst_n_i)
      up_last_r <= 1'b0;
    else if (up_wr)
      up_last_r <= wr_data[0];
  sequence s_up_rise;
    up_wr && wr_data[0] && !up_last_r ##0 up_jam_i;
  endsequence
  // Quiet cycle first, so a pulse from an earlier edge is not blamed
  sequence s_up_hold;
    !up_wr ##1 up_wr && wr_data[0] && up_last_r;
  endsequence
  chk_stop_set: assert property (stop_set |=> stopped_o)
    else $error("stop not set");
  chk_stop_clear: assert property (stop_clr |=> !stopped_o)
    else $error("stop not cleared");
  chk_stop_idle: assert property (!(stop_set || stop_clr) |=> $stable(stopped_o))
    else $error("stop changed without command");
  chk_jam_fire: assert property (s_up_rise |=> up_jam_clear_o)
    else $error("jam clear missing");
  chk_jam_hold: assert property (s_up_hold |=> !up_jam_clear_o)
    else $error("jam clear on held bit");
  chk_jam_cause: assert property (!up_wr |=> !up_jam_clear_o)
    else $error("jam clear without write");
  chk_aux_dir: assert property (aux_wr && aux_usage_none_l_i
    |=> aux_oe_l_o == $past(wr_data[8]))
    else $error("aux direction wrong");
  chk_aux_lock: assert property (aux_wr && !aux_usage_none_l_i |=> $stable(aux_oe_l_o))
    else $error("aux changed while locked");
  chk_fault_latch: assert property (fault_left_i |=> fault_left_o)
    else $error("fault not latched");
endmodule : chr_asserts

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_valid = 1'b0;
  logic [8:0] cmd_addr = 9'h000;
  logic [15:0] cmd_data = 16'h0000;
  logic [1:0] fault = 2'h0;
  logic [1:0] use_none = 2'h0;
  logic [1:0] jam = 2'h0;
  logic [1:0] blk = 2'h0;
  logic [1:0] flt, oe, dout, jclr, rev, alt, acc;
  logic stopped;
  logic [1:0] ain;
  chr_pkg::chr_mode_type mode [2];
  logic [7:0] zones [2];
  int failures = 0;
  int checks_done = 0;
  int n;
  chr_if bus_if ();
  always #20 clk_sys_i = ~clk_sys_i;
  chr_host chr_host_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid),
    .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data), .cmd_ready_o(), .bus(bus_if.host));
  // Short hold count keeps the fault clear run brief
  chr_device #(.HOLD_CYCLES(20)) chr_device_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .bus(bus_if.device), .fault_left_i(fault[0]), .fault_right_i(fault[1]),
    .fault_left_o(flt[0]), .fault_right_o(flt[1]), .aux_usage_none_l_i(use_none[0]),
    .aux_usage_none_r_i(use_none[1]), .aux_in_l_i(1'b1), .aux_in_r_i(1'b0),
    .aux_out_l_o(dout[0]), .aux_out_r_o(dout[1]), .aux_oe_l_o(oe[0]), .aux_oe_r_o(oe[1]),
    .aux_in_o(ain), .stopped_o(stopped), .up_jam_i(jam[0]), .dn_jam_i(jam[1]),
    .up_jam_clear_o(jclr[0]), .dn_jam_clear_o(jclr[1]), .up_blocked_i(blk[0]),
    .dn_blocked_i(blk[1]), .up_mode_o(mode[0]), .dn_mode_o(mode[1]), .up_reverse_o(rev[0]),
    .dn_reverse_o(rev[1]), .up_alt_release_o(alt[0]), .dn_alt_release_o(alt[1]),
    .up_zones_o(zones[0]), .dn_zones_o(zones[1]), .up_accumulate_o(acc[0]),
    .dn_accumulate_o(acc[1]));
  chr_asserts chr_asserts_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .wr_en(bus_if.wr_en), .wr_addr(bus_if.wr_addr), .wr_data(bus_if.wr_data),
    .stopped_o(stopped), .fault_left_i(fault[0]), .fault_left_o(flt[0]),
    .aux_usage_none_l_i(use_none[0]), .aux_oe_l_o(oe[0]), .up_jam_i(jam[0]),
    .up_jam_clear_o(jclr[0]));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Ends just after the device's write edge, where its outputs have settled
  task wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    cmd_valid <= 1'b1;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge clk_sys_i);
    cmd_valid <= 1'b0;
    @(posedge clk_sys_i);
    #1;
  endtask : wr
  task cyc(input int c);
    repeat (c) @(posedge clk_sys_i);
    #1;
  endtask : cyc
  task t_stop();
    wr(chr_pkg::ADDR_STOP_CMD, chr_pkg::STOP_SET);
    chk(16'(stopped), 16'h1);
    wr(chr_pkg::ADDR_STOP_CMD, chr_pkg::STOP_NONE);
    chk(16'(stopped), 16'h1);
    wr(9'h015, chr_pkg::STOP_CLEAR);
    chk(16'(stopped), 16'h1);
    wr(chr_pkg::ADDR_STOP_CMD, 16'h0003);
    chk(16'(stopped), 16'h1);
    wr(chr_pkg::ADDR_STOP_CMD, chr_pkg::STOP_CLEAR);
    chk(16'(stopped), 16'h0);
  endtask : t_stop
  task t_aux();
    @(posedge clk_sys_i);
    use_none <= 2'b01;
    wr(chr_pkg::ADDR_AUX_CTRL, 16'h3300);
    chk(16'(oe), 16'h1);
    chk(16'(dout[0]), 16'h1);
    chk(16'(ain), 16'h1);
    @(posedge clk_sys_i);
    use_none <= 2'b11;
    wr(chr_pkg::ADDR_AUX_CTRL, 16'h2200);
    chk(16'(oe), 16'h2);
    chk(16'(dout[1]), 16'h1);
    wr(chr_pkg::ADDR_AUX_CTRL, 16'hfcff);
    chk(16'(oe), 16'h0);
    chk(16'(dout), 16'h0);
    wr(chr_pkg::ADDR_AUX_CTRL, 16'h3300);
    @(posedge clk_sys_i);
    use_none <= 2'b00;
    wr(chr_pkg::ADDR_AUX_CTRL, 16'h0000);
    chk(16'(oe), 16'h3);
    chk(16'(dout), 16'h3);
  endtask : t_aux
  // Counts pulse cycles over three cycles, latency slack included
  task jw(input int s, input logic [15:0] d);
    wr(s ? chr_pkg::ADDR_DN_JAM : chr_pkg::ADDR_UP_JAM, d);
    n = int'(jclr[s]);
    cyc(1);
    n += int'(jclr[s]);
    cyc(1);
    n += int'(jclr[s]);
  endtask : jw
  task t_jam(input int s);
    @(posedge clk_sys_i);
    jam[s] <= 1'b1;
    jw(s, 16'h0001);
    chk(16'(n), 16'h1);
    jw(s, 16'h0001);
    chk(16'(n), 16'h0);
    jw(s, 16'h0000);
    @(posedge clk_sys_i);
    jam[s] <= 1'b0;
    jw(s, 16'h0001);
    chk(16'(n), 16'h0);
  endtask : t_jam
  task fl(input int s, input logic [15:0] d, input chr_pkg::chr_mode_type m,
    input logic [7:0] z);
    wr(s ? chr_pkg::ADDR_DN_FLOW : chr_pkg::ADDR_UP_FLOW, d);
    chk(16'(mode[s]), 16'(m));
    chk(16'(zones[s]), 16'(z));
  endtask : fl
  task t_flow(input int s);
    fl(s, {8'h05, chr_pkg::FLOW_RUN_FWD}, chr_pkg::MODE_RUN_FWD, 8'h05);
    fl(s, {8'h00, chr_pkg::FLOW_RUN_REV}, chr_pkg::MODE_RUN_REV, 8'h00);
    fl(s, {8'hdd, chr_pkg::FLOW_MAINT}, chr_pkg::MODE_MAINT, 8'hdc);
    fl(s, {8'h01, 8'h08}, chr_pkg::MODE_MAINT, 8'hdc);
    fl(s, {8'hdc, chr_pkg::FLOW_NORMAL}, chr_pkg::MODE_NORMAL, 8'hdc);
    fl(s, {8'h01, 8'hff}, chr_pkg::MODE_NORMAL, 8'hdc);
    fl(s, {8'h01, chr_pkg::FLOW_DIR_OPP}, chr_pkg::MODE_NORMAL, 8'h01);
    chk(16'(rev[s]), 16'h1);
    fl(s, {8'h01, chr_pkg::FLOW_DIR_DEF}, chr_pkg::MODE_NORMAL, 8'h01);
    chk(16'(rev[s]), 16'h0);
    fl(s, {8'h02, chr_pkg::FLOW_CHG_REL}, chr_pkg::MODE_NORMAL, 8'h02);
    chk(16'(alt[s]), 16'h1);
    fl(s, {8'h02, chr_pkg::FLOW_DEF_REL}, chr_pkg::MODE_NORMAL, 8'h02);
    chk(16'(alt[s]), 16'h0);
    @(posedge clk_sys_i);
    blk[s] <= 1'b1;
    fl(s, {8'h02, chr_pkg::FLOW_ACCUM_A}, chr_pkg::MODE_ACCUM, 8'h02);
    cyc(2);
    chk(16'(acc[s]), 16'h0);
    @(posedge clk_sys_i);
    blk[s] <= 1'b0;
    cyc(2);
    @(posedge clk_sys_i);
    blk[s] <= 1'b1;
    cyc(3);
    chk(16'(acc[s]), 16'h1);
    fl(s, {8'h03, chr_pkg::FLOW_ACCUM_B}, chr_pkg::MODE_ACCUM, 8'h03);
  endtask : t_flow
  task t_fault();
    @(posedge clk_sys_i);
    fault <= 2'b11;
    @(posedge clk_sys_i);
    fault <= 2'b00;
    cyc(30);
    chk(16'(flt), 16'h3);
    wr(chr_pkg::ADDR_FAULT_CLR, 16'h0001);
    cyc(10);
    wr(chr_pkg::ADDR_FAULT_CLR, 16'h0000);
    cyc(20);
    chk(16'(flt), 16'h3);
    wr(chr_pkg::ADDR_FAULT_CLR, 16'h0001);
    cyc(15);
    chk(16'(flt), 16'h3);
    cyc(10);
    chk(16'(flt), 16'h0);
  endtask : t_fault
  task final_report();
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_stop();
    t_aux();
    t_jam(0);
    t_jam(1);
    t_flow(0);
    t_flow(1);
    t_fault();
    final_report();
  end
  // Whole run is well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    failures++;
    final_report();
  end
endmodule : tb
